// file: logic/onchip_expanded_ram_decode_pkg.sv
package onchip_expanded_ram_decode_pkg;
   localparam logic [7:0] AUX_MEM_ADDR = 8'h8E;
   localparam logic [7:0] AUX_PTR_ADDR = 8'hA2;
   localparam logic [7:0] CLK_CTRL_ADDR = 8'h8F;
   localparam int BYPASS_BIT = 1;
   localparam int SUPPRESS_BIT = 0;
   localparam int PSEL_BIT = 0;
   localparam int FLAG_BIT = 3;
   localparam int DSPEED_BIT = 0;
   localparam logic RST_BYPASS = 1'b0;
   localparam logic RST_SUPPRESS = 1'b0;
   localparam logic RST_PSEL = 1'b0;
   localparam logic RST_FLAG = 1'b0;
   localparam logic RST_DSPEED = 1'b0;
   localparam logic [15:0] RST_PTR = 16'h0000;
   localparam logic [7:0] LOWER_TOP = 8'h7F;
   localparam int ONCHIP_EXPANDED_RAM_SMALL = 256;
   localparam int ONCHIP_EXPANDED_RAM_LARGE = 768;
   localparam logic [2:0] ALE_DIV_STD = 3'h6;
   localparam logic [2:0] ALE_DIV_FAST = 3'h3;
   localparam logic [1:0] STROBE_CYCLES = 2'h3;

   typedef enum logic [3:0] {
      BUS_IDLE = 4'b0001,
      BUS_ADDR = 4'b0010,
      BUS_STRB = 4'b0100,
      BUS_DONE = 4'b1000
   } bus_state_e;

   typedef struct packed {
      logic wr;
      logic use_ptr;
      logic [7:0] ind_addr;
      logic [7:0] wdata;
   } xmove_req_s;

   typedef struct packed {
      logic lower;
      logic upper;
      logic special_function_space;
   } idata_sel_s;
endpackage

// file: logic/dual_pointer_onchip_expanded_ram_decode.sv
`timescale 1ns/1ns
module dual_pointer_onchip_expanded_ram_decode
   import onchip_expanded_ram_decode_pkg::*;
#(
   parameter int ONCHIP_EXPANDED_RAM_BYTES = ONCHIP_EXPANDED_RAM_LARGE
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata_r,
   input wire logic aux_inc,
   input wire logic ptr_load,
   input wire logic [15:0] ptr_load_val,
   input wire logic ptr_inc,
   output logic [15:0] ptr_value_r,
   input wire logic idata_valid,
   input wire logic idata_direct,
   input wire logic idata_stack,
   input wire logic [7:0] idata_addr,
   output idata_sel_s idata_sel_r,
   input wire logic xmove_valid,
   input wire xmove_req_s xmove,
   output logic xmove_busy_r,
   output logic xmove_done_r,
   output logic [7:0] xmove_rdata_r,
   input wire logic move_instr_active,
   input wire logic [7:0] port0_in,
   output logic [7:0] port0_out_r,
   output logic port0_oe_n_r,
   output logic [7:0] port2_out_r,
   output logic port2_oe_n_r,
   output logic wr_n_r,
   output logic rd_n_r,
   output logic ale_r,
   output logic double_speed_r
);
   localparam int XA = $clog2(ONCHIP_EXPANDED_RAM_BYTES);
   localparam logic [16:0] XTOP = 17'(ONCHIP_EXPANDED_RAM_BYTES);

   logic bypass_r;
   logic suppress_r;
   logic psel_r;
   logic flag3_r;
   logic [15:0] ptr_r [2];
   logic [7:0] onchip_expanded_ram_mem [ONCHIP_EXPANDED_RAM_BYTES];
   bus_state_e state_r;
   logic [1:0] cnt_r;
   logic req_wr_r;
   logic req_ptr_r;
   logic [15:0] req_addr_r;
   logic [7:0] req_wdata_r;
   logic [7:0] p0_s1_r;
   logic [7:0] p0_s2_r;
   logic [2:0] div_r;
   logic tick;
   logic accept;
   logic to_onchip_expanded_ram;
   logic [15:0] acc_addr;
   logic idata_hi;
   logic [15:0] ptr0;
   logic [15:0] ptr1;

   function automatic logic in_onchip_expanded_ram(input logic [15:0] a);
      in_onchip_expanded_ram = {1'b0, a} < XTOP;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
      hit = a == reg_addr;
   endfunction

   // Control registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         bypass_r <= RST_BYPASS;
         suppress_r <= RST_SUPPRESS;
         double_speed_r <= RST_DSPEED;
      end
      else if (sfr_wr)
      begin
         if (hit(sfr_addr, AUX_MEM_ADDR))
         begin
            bypass_r <= sfr_wdata[BYPASS_BIT];
            suppress_r <= sfr_wdata[SUPPRESS_BIT];
         end
         if (hit(sfr_addr, CLK_CTRL_ADDR))
            double_speed_r <= sfr_wdata[DSPEED_BIT];
      end
   end

   // Pointer select and user flag
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         psel_r <= RST_PSEL;
         flag3_r <= RST_FLAG;
      end
      else
      begin
         if (aux_inc)
            psel_r <= ~psel_r;
         else if (sfr_wr && hit(sfr_addr, AUX_PTR_ADDR))
            psel_r <= sfr_wdata[PSEL_BIT];
         if (sfr_wr && hit(sfr_addr, AUX_PTR_ADDR))
            flag3_r <= sfr_wdata[FLAG_BIT];
      end
   end

   // Readback, reserved bits zero
   always_ff @(posedge clk)
   begin
      if (reset)
         sfr_rdata_r <= 8'h00;
      else
      begin
         sfr_rdata_r <= 8'h00;
         if (sfr_rd && hit(sfr_addr, AUX_MEM_ADDR))
         begin
            sfr_rdata_r[BYPASS_BIT] <= bypass_r;
            sfr_rdata_r[SUPPRESS_BIT] <= suppress_r;
         end
         else if (sfr_rd && hit(sfr_addr, AUX_PTR_ADDR))
         begin
            sfr_rdata_r[PSEL_BIT] <= psel_r;
            sfr_rdata_r[FLAG_BIT] <= flag3_r;
         end
         else if (sfr_rd && hit(sfr_addr, CLK_CTRL_ADDR))
            sfr_rdata_r[DSPEED_BIT] <= double_speed_r;
      end
   end

   // Two pointers, only the selected one moves
   for (genvar g = 0; g < 2; g++)
   begin : g_ptr
      always_ff @(posedge clk)
      begin
         if (reset)
            ptr_r[g] <= RST_PTR;
         else if (psel_r == 1'(g))
         begin
            if (ptr_load)
               ptr_r[g] <= ptr_load_val;
            else if (ptr_inc)
               ptr_r[g] <= ptr_r[g] + 16'h0001;
         end
      end
   end

   assign ptr0 = ptr_r[0];
   assign ptr1 = ptr_r[1];

   always_ff @(posedge clk)
   begin
      if (reset)
         ptr_value_r <= RST_PTR;
      else
         ptr_value_r <= ptr_r[psel_r];
   end

   // Internal data space steering
   assign idata_hi = idata_addr > LOWER_TOP;

   always_ff @(posedge clk)
   begin
      if (reset)
         idata_sel_r <= '0;
      else if (idata_valid)
      begin
         idata_sel_r.lower <= !idata_hi;
         idata_sel_r.upper <= idata_hi && (!idata_direct || idata_stack);
         idata_sel_r.special_function_space <= idata_hi && idata_direct && !idata_stack;
      end
      else
         idata_sel_r <= '0;
   end

   // External move routing
   assign acc_addr = xmove.use_ptr ? ptr_r[psel_r] : {8'h00, xmove.ind_addr};
   assign to_onchip_expanded_ram = !bypass_r && (!xmove.use_ptr || in_onchip_expanded_ram(acc_addr));
   assign accept = xmove_valid && !xmove_busy_r && state_r == BUS_IDLE;

   always_ff @(posedge clk)
   begin
      if (accept && to_onchip_expanded_ram && xmove.wr)
         onchip_expanded_ram_mem[acc_addr[XA-1:0]] <= xmove.wdata;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         xmove_rdata_r <= 8'h00;
      else if (accept && to_onchip_expanded_ram && !xmove.wr)
         xmove_rdata_r <= onchip_expanded_ram_mem[acc_addr[XA-1:0]];
      else if (state_r == BUS_STRB && cnt_r == STROBE_CYCLES - 2'h1 && !req_wr_r)
         xmove_rdata_r <= p0_s2_r;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         xmove_busy_r <= 1'b0;
         xmove_done_r <= 1'b0;
      end
      else
      begin
         xmove_done_r <= (accept && to_onchip_expanded_ram) || (state_r == BUS_STRB && cnt_r == STROBE_CYCLES - 2'h1);
         if (accept && !to_onchip_expanded_ram)
            xmove_busy_r <= 1'b1;
         else if (state_r == BUS_DONE)
            xmove_busy_r <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         req_wr_r <= 1'b0;
         req_ptr_r <= 1'b0;
         req_addr_r <= 16'h0000;
         req_wdata_r <= 8'h00;
      end
      else if (accept && !to_onchip_expanded_ram)
      begin
         req_wr_r <= xmove.wr;
         req_ptr_r <= xmove.use_ptr;
         req_addr_r <= acc_addr;
         req_wdata_r <= xmove.wdata;
      end
   end

   // Read data from the pins
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         p0_s1_r <= 8'h00;
         p0_s2_r <= 8'h00;
      end
      else
      begin
         p0_s1_r <= port0_in;
         p0_s2_r <= p0_s1_r;
      end
   end

   // External bus cycle
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_r <= BUS_IDLE;
         cnt_r <= 2'h0;
         port0_out_r <= 8'h00;
         port0_oe_n_r <= 1'b1;
         port2_out_r <= 8'hFF;
         port2_oe_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         rd_n_r <= 1'b1;
      end
      else
      begin
         case (state_r)
            BUS_IDLE:
            begin
               if (accept && !to_onchip_expanded_ram)
               begin
                  state_r <= BUS_ADDR;
                  port0_out_r <= acc_addr[7:0];
                  port0_oe_n_r <= 1'b0;
                  if (xmove.use_ptr)
                  begin
                     port2_out_r <= acc_addr[15:8];
                     port2_oe_n_r <= 1'b0;
                  end
               end
            end
            BUS_ADDR:
            begin
               state_r <= BUS_STRB;
               cnt_r <= 2'h0;
               if (req_wr_r)
               begin
                  port0_out_r <= req_wdata_r;
                  wr_n_r <= 1'b0;
               end
               else
               begin
                  port0_oe_n_r <= 1'b1;
                  rd_n_r <= 1'b0;
               end
            end
            BUS_STRB:
            begin
               if (cnt_r == STROBE_CYCLES - 2'h1)
               begin
                  state_r <= BUS_DONE;
                  wr_n_r <= 1'b1;
                  rd_n_r <= 1'b1;
               end
               else
                  cnt_r <= cnt_r + 2'h1;
            end
            BUS_DONE:
            begin
               state_r <= BUS_IDLE;
               port0_oe_n_r <= 1'b1;
               port2_oe_n_r <= 1'b1;
            end
            default:
               state_r <= BUS_IDLE;
         endcase
      end
   end

   // Latch strobe divider and gating
   assign tick = div_r == 3'h0;

   always_ff @(posedge clk)
   begin
      if (reset)
         div_r <= 3'h0;
      else if (div_r >= (double_speed_r ? ALE_DIV_FAST : ALE_DIV_STD) - 3'h1)
         div_r <= 3'h0;
      else
         div_r <= div_r + 3'h1;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         ale_r <= 1'b0;
      else
         ale_r <= (tick && (!suppress_r || move_instr_active)) || (accept && !to_onchip_expanded_ram);
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   AST_PTR_ISOLATED: assert property (
      (ptr_load || ptr_inc) |=> ($past(psel_r) ? $stable(ptr0) : $stable(ptr1)))
      else $error("unselected pointer changed");
   AST_FLAG_WRITE: assert property (
      sfr_wr && hit(sfr_addr, AUX_PTR_ADDR) && !aux_inc |=>
      flag3_r == $past(sfr_wdata[FLAG_BIT]) && psel_r == $past(sfr_wdata[PSEL_BIT]))
      else $error("pointer control write lost");
   AST_INC_TOGGLE: assert property (
      aux_inc |=> psel_r != $past(psel_r))
      else $error("increment did not toggle select");
   AST_RESERVED_ZERO: assert property (
      sfr_rd && (hit(sfr_addr, AUX_PTR_ADDR) || hit(sfr_addr, AUX_MEM_ADDR)) |=>
      (sfr_rdata_r & 8'hF4) == 8'h00)
      else $error("reserved bit read nonzero");
   AST_DIRECT_HIGH_SFR: assert property (
      idata_valid && idata_direct && !idata_stack && idata_hi |=> idata_sel_r.special_function_space && !idata_sel_r.upper)
      else $error("direct high access not to sfr");
   AST_STACK_RAM: assert property (
      idata_valid && idata_stack |=> !idata_sel_r.special_function_space && (idata_sel_r.lower ^ idata_sel_r.upper))
      else $error("stack left internal ram");
   AST_ONCHIP_EXPANDED_RAM_QUIET: assert property (
      accept && to_onchip_expanded_ram |=> xmove_done_r && wr_n_r && rd_n_r && $stable(port0_out_r) && $stable(port2_out_r))
      else $error("on-chip move disturbed bus");
   AST_PTR_RANGE: assert property (
      accept && xmove.use_ptr && !bypass_r |-> to_onchip_expanded_ram == (ptr_r[psel_r] <= 16'(ONCHIP_EXPANDED_RAM_BYTES - 1)))
      else $error("pointer range decode wrong");
   AST_BUS_ADDR: assert property (
      accept && !to_onchip_expanded_ram |=> ale_r && !port0_oe_n_r && port0_out_r == req_addr_r[7:0])
      else $error("bus address phase wrong");
   AST_P2_HIGH: assert property (
      state_r == BUS_ADDR |-> (req_ptr_r ? (!port2_oe_n_r && port2_out_r == req_addr_r[15:8]) : port2_oe_n_r))
      else $error("port 2 address wrong");
   AST_WR_STROBE: assert property (
      state_r == BUS_ADDR && req_wr_r |=> (!wr_n_r && rd_n_r)[*3] ##1 wr_n_r)
      else $error("write strobe length wrong");
   AST_RD_STROBE: assert property (
      state_r == BUS_ADDR && !req_wr_r |=> (!rd_n_r && wr_n_r)[*3] ##1 rd_n_r ##1 !xmove_busy_r)
      else $error("read strobe length wrong");
   AST_ALE_QUIET: assert property (
      suppress_r && !move_instr_active && !accept |=> !ale_r)
      else $error("latch strobe not suppressed");
   AST_ALE_STD: assert property (
      (tick && !double_speed_r ##1 !double_speed_r [*5]) |=> tick)
      else $error("standard strobe period wrong");
   AST_ALE_FAST: assert property (
      (tick && double_speed_r ##1 double_speed_r [*2]) |=> tick)
      else $error("double speed strobe period wrong");
   AST_RESET_VALUES: assert property (
      disable iff (1'b0) reset |=> !bypass_r && !suppress_r && !psel_r && !flag3_r && !double_speed_r)
      else $error("reset values wrong");

   COV_BUS_READ: cover property (state_r == BUS_ADDR && !req_wr_r ##4 xmove_done_r);
   COV_BUS_WRITE: cover property (state_r == BUS_ADDR && req_wr_r && req_ptr_r);
   COV_ONCHIP_EXPANDED_RAM_HIGH: cover property (accept && to_onchip_expanded_ram && acc_addr > 16'h00FF);
   COV_TOGGLE: cover property (aux_inc ##1 ptr_inc ##1 aux_inc);
endmodule

// file: testbench/ext_mem_model.sv
`timescale 1ns/1ns
module ext_mem_model
(
   input wire logic clk,
   input wire logic [7:0] port0_out_r,
   input wire logic port0_oe_n_r,
   input wire logic [7:0] port2_out_r,
   input wire logic port2_oe_n_r,
   input wire logic ale_r,
   input wire logic wr_n_r,
   input wire logic rd_n_r,
   output logic [7:0] port0_in,
   output logic [15:0] cap_addr
);
   logic [7:0] mem [0:65535];
   logic [7:0] last = 8'h00;
   logic held = 1'b0;
   initial cap_addr = 16'h0000;
   // Address taken once per cycle, high byte only when port 2 drives
   always @(posedge clk)
   begin
      last <= port0_in;
      if (port0_oe_n_r)
         held <= 1'b0;
      else if (ale_r && !held)
      begin
         held <= 1'b1;
         cap_addr <= {port2_oe_n_r ? 8'h00 : port2_out_r, port0_out_r};
      end
      if (!wr_n_r)
         mem[cap_addr] <= port0_out_r;
   end
   // Data only while read strobe low, else changing pattern
   assign port0_in = rd_n_r ? ~last : mem[cap_addr];
endmodule

// file: testbench/dual_pointer_onchip_expanded_ram_decode_tb.sv
`timescale 1ns/1ns
module dual_pointer_onchip_expanded_ram_decode_tb;
   import onchip_expanded_ram_decode_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic sfr_wr = 1'b0, sfr_rd = 1'b0, aux_inc = 1'b0, ptr_load = 1'b0, ptr_inc = 1'b0;
   logic idata_valid = 1'b0, idata_direct = 1'b0, idata_stack = 1'b0;
   logic xmove_valid = 1'b0, move_instr_active = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, idata_addr = 8'h00, sfr_rdata_r, xmove_rdata_r, rv;
   logic [7:0] port0_in, port0_out_r, port2_out_r;
   logic [15:0] ptr_load_val = 16'h0000, ptr_value_r, cap_addr;
   xmove_req_s xmove = '0;
   idata_sel_s idata_sel_r;
   logic xmove_busy_r, xmove_done_r, port0_oe_n_r, port2_oe_n_r, wr_n_r, rd_n_r, ale_r, double_speed_r;
   int mismatches = 0, num_checks = 0, cycles = 0, strb = 0, p2 = 0, ales = 0, bsy = 0, s, p, b;
   logic [12:0] itab [6] = '{{2'b10, 8'h7F, 3'b100}, {2'b00, 8'h7F, 3'b100}, {2'b10, 8'h80, 3'b001},
      {2'b00, 8'h80, 3'b010}, {2'b11, 8'hFF, 3'b010}, {2'b00, 8'hFF, 3'b010}};

   dual_pointer_onchip_expanded_ram_decode #(.ONCHIP_EXPANDED_RAM_BYTES(ONCHIP_EXPANDED_RAM_LARGE)) dut (.*);
   ext_mem_model partner (.*);

   initial forever #25 clk = ~clk;

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      strb <= strb + int'(!wr_n_r || !rd_n_r);
      p2 <= p2 + int'(!port2_oe_n_r);
      ales <= ales + int'(ale_r);
      bsy <= bsy + int'(xmove_busy_r);
      if (cycles == 5000)
      begin
         mismatches++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask

   task automatic sfr_r(input logic [7:0] a);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      #1;
      rv = sfr_rdata_r;
   endtask

   task automatic ld(input logic [15:0] v);
      @(posedge clk);
      ptr_load_val <= v;
      ptr_load <= 1'b1;
      @(posedge clk);
      ptr_load <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic inc_aux(input logic which);
      @(posedge clk);
      aux_inc <= !which;
      ptr_inc <= which;
      @(posedge clk);
      aux_inc <= 1'b0;
      ptr_inc <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic xm(input logic w, input logic up, input logic [7:0] ia, input logic [7:0] wd);
      int n;
      @(posedge clk);
      xmove <= {w, up, ia, wd};
      xmove_valid <= 1'b1;
      @(posedge clk);
      xmove_valid <= 1'b0;
      n = 0;
      #1;
      while (xmove_done_r !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk(16'(xmove_done_r), 16'h0001, "move done");
      rv = xmove_rdata_r;
      repeat (3) @(posedge clk);
   endtask

   task automatic t_reset;
      sfr_r(AUX_MEM_ADDR);
      chk(16'(rv), 16'h0000, "aux mem reset");
      sfr_r(AUX_PTR_ADDR);
      chk(16'(rv), 16'h0000, "aux ptr reset");
      sfr_r(CLK_CTRL_ADDR);
      chk(16'(rv), 16'h0000, "speed reset");
      chk(16'({port2_out_r, port2_oe_n_r, wr_n_r, rd_n_r}), 16'h07FF, "idle pins");
      $display("t_reset done");
   endtask

   task automatic t_regs;
      sfr_w(AUX_PTR_ADDR, 8'h01);
      sfr_r(AUX_PTR_ADDR);
      chk(16'(rv), 16'h0001, "select only");
      sfr_w(AUX_PTR_ADDR, 8'h09);
      sfr_r(AUX_PTR_ADDR);
      chk(16'(rv), 16'h0009, "flag and select");
      sfr_w(AUX_MEM_ADDR, 8'h03);
      sfr_r(AUX_MEM_ADDR);
      chk(16'(rv), 16'h0003, "mem bits");
      sfr_w(AUX_MEM_ADDR, 8'h00);
      sfr_w(8'h8D, 8'hFF);
      sfr_r(8'h8D);
      chk(16'(rv), 16'h0000, "unmapped");
      sfr_w(AUX_PTR_ADDR, 8'h08);
      $display("t_regs done");
   endtask

   task automatic t_ptr;
      ld(16'h1234);
      chk(ptr_value_r, 16'h1234, "pointer zero");
      inc_aux(1'b0);
      sfr_r(AUX_PTR_ADDR);
      chk(16'(rv), 16'h0009, "toggle keeps flag");
      ld(16'hABCD);
      chk(ptr_value_r, 16'hABCD, "pointer one");
      inc_aux(1'b0);
      chk(ptr_value_r, 16'h1234, "back to zero");
      inc_aux(1'b1);
      chk(ptr_value_r, 16'h1235, "pointer inc");
      $display("t_ptr done");
   endtask

   task automatic t_idata;
      foreach (itab[i])
      begin
         @(posedge clk);
         {idata_direct, idata_stack, idata_addr} <= itab[i][12:3];
         idata_valid <= 1'b1;
         @(posedge clk);
         idata_valid <= 1'b0;
         #1;
         chk(16'(idata_sel_r), 16'(itab[i][2:0]), "idata steer");
      end
      $display("t_idata done");
   endtask

   task automatic t_onchip_expanded_ram;
      s = strb;
      ld(16'h02FF);
      xm(1'b1, 1'b1, 8'h00, 8'h5A);
      xm(1'b0, 1'b1, 8'h00, 8'h00);
      chk(16'(rv), 16'h005A, "top of onchip_expanded_ram");
      ld(16'h0020);
      xm(1'b1, 1'b0, 8'h20, 8'h11);
      xm(1'b0, 1'b1, 8'h00, 8'h00);
      chk(16'(rv), 16'h0011, "indirect and pointer share");
      chk(16'(strb - s), 16'h0000, "no strobes on chip");
      ld(16'h0300);
      b = bsy;
      xm(1'b1, 1'b1, 8'h00, 8'hC3);
      chk(16'(strb - s), 16'(STROBE_CYCLES), "write strobe");
      chk(16'(bsy - b), 16'(STROBE_CYCLES + 2), "busy length");
      chk(cap_addr, 16'h0300, "bus address");
      xm(1'b0, 1'b1, 8'h00, 8'h00);
      chk(16'(rv), 16'h00C3, "bus read");
      $display("t_onchip_expanded_ram done");
   endtask

   task automatic t_bypass;
      sfr_w(AUX_MEM_ADDR, 8'h02);
      s = strb;
      p = p2;
      xm(1'b1, 1'b0, 8'h40, 8'h66);
      chk(cap_addr, 16'h0040, "indirect bus address");
      chk(16'(p2 - p), 16'h0000, "port 2 released");
      xm(1'b0, 1'b0, 8'h40, 8'h00);
      chk(16'(rv), 16'h0066, "indirect bus read");
      chk(16'(strb - s), 16'(2 * STROBE_CYCLES), "indirect strobes");
      ld(16'h0010);
      xm(1'b1, 1'b1, 8'h00, 8'h77);
      chk(cap_addr, 16'h0010, "pointer bypass");
      chk(16'(p2 > p), 16'h0001, "port 2 driven");
      sfr_w(AUX_MEM_ADDR, 8'h00);
      $display("t_bypass done");
   endtask

   task automatic cnt(input int exp);
      int a;
      repeat (2) @(posedge clk);
      #1;
      a = ales;
      repeat (60) @(posedge clk);
      #1;
      chk(16'(ales - a), 16'(exp), "latch strobes");
      @(posedge clk);
   endtask

   task automatic t_ale;
      cnt(60 / int'(ALE_DIV_STD));
      sfr_w(CLK_CTRL_ADDR, 8'h01);
      cnt(60 / int'(ALE_DIV_FAST));
      chk(16'(double_speed_r), 16'h0001, "speed bit");
      sfr_w(AUX_MEM_ADDR, 8'h01);
      cnt(0);
      move_instr_active <= 1'b1;
      cnt(60 / int'(ALE_DIV_FAST));
      move_instr_active <= 1'b0;
      sfr_w(AUX_MEM_ADDR, 8'h00);
      $display("t_ale done");
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_regs();
      t_ptr();
      t_idata();
      t_onchip_expanded_ram();
      t_bypass();
      t_ale();
      report_and_stop();
   end
endmodule
